// *** shared/hcg_pkg.sv ***
// constants and types shared by the clock control block
//
// Overview of operation
// - writing one leaves clock loss flag unchanged
// - monitor enable stays set despite lost stability
// - detection valid only with matching slow option
// - inactive clock deselected, survivor drives both clocks
// - quantization error set by divider and span
// - divider field divides by two to power
// - divider moves only by stage field carry
// - upper stage bits give 17 to 31
// - stage bit five step is coarse correction
// - lower stage bits lengthen k of 32
// - code seven dithers 31 against doubled 17
// - stage bit zero is finest correction
// - internal clock is multiplier times base clock
// - monitor enable refused until stable after change
// - settling after reset, multiplier, trim, restart
// - correction step spans four base periods
// - source select one picks external clock
// - monitor enable needs both stable flags
`default_nettype none
package hcg_pkg;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] OFF_MULT = 5'h04;
  localparam logic [ADDR_W-1:0] OFF_TRIM = 5'h08;
  localparam logic [ADDR_W-1:0] OFF_DCO = 5'h0c;
  localparam logic [ADDR_W-1:0] OFF_STAT = 5'h10;
  // control register bits
  localparam int B_INT_STABLE = 0;
  localparam int B_INT_ON = 1;
  localparam int B_EXT_STABLE = 2;
  localparam int B_EXT_ON = 3;
  localparam int B_SEL_EXT = 4;
  localparam int B_MON_EN = 5;
  localparam int B_LOSS = 6;
  localparam int B_IRQ_EN = 7;
  // status register fields
  localparam int S_SETTLING = 0;
  localparam int S_DIV_LSB = 1;
  localparam int S_RING_LSB = 5;
  localparam int S_DIV2 = 10;
  localparam int S_SLOW_EXT = 11;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // oscillator encoding
  localparam logic [3:0] DIV_MAX = 4'h9;
  localparam logic [11:0] DCO_MAX = 12'h09ff;
  localparam logic [11:0] STEP_COARSE = 12'h0020;
  localparam logic [11:0] STEP_FINE = 12'h0001;
  localparam logic [4:0] RING_MIN = 5'h11;
  localparam logic [4:0] RING_STEP = 5'h02;
  localparam logic [2:0] STG_TOP = 3'h7;
  localparam int CORR_BASE_PERIODS = 4;
  localparam int BASE_FREQ_HZ = 307200;
  localparam logic [7:0] TRIM_RST = 8'h80;
  typedef enum logic [0:0] {RD_IDLE, RD_DATA} hcg_rd_e;
endpackage : hcg_pkg
`default_nettype wire

// *** hw/hcg_sync.sv ***
// three-stage input synchroniser with agreement filter
`default_nettype none
module hcg_sync #(
  parameter int W = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] o;
  } hcg_sync_s;
  hcg_sync_s q, d;

  always_comb begin
    d = q;
    d.s1 = din;
    d.s2 = q.s1;
    d.s3 = q.s2;
    // s1 may be metastable, so only s2 and s3 vote
    for (int i = 0; i < W; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        d.o[i] = q.s3[i];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign dout = q.o;
endmodule : hcg_sync
`default_nettype wire

// *** hw/hcg_dither.sv ***
// ring length and fine-adjust dither sequencer
`default_nettype none
module hcg_dither (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] osc_stage_field,
  output logic [4:0] ring_stages,
  output logic ring_div2
);
  import hcg_pkg::*;
  typedef struct packed {
    logic [4:0] acc;
    logic [4:0] ring;
    logic div2;
  } hcg_dith_s;
  hcg_dith_s q, d;
  logic [5:0] sum;
  logic [4:0] base;

  always_comb begin
    d = q;
    // accumulator spreads k long cycles evenly over 32
    sum = {1'b0, q.acc} + {1'b0, osc_stage_field[4:0]};
    d.acc = sum[4:0];
    base = RING_MIN + 5'(RING_STEP * osc_stage_field[7:5]);
    d.ring = base;
    d.div2 = 1'b0;
    if (sum[5]) begin
      if (osc_stage_field[7:5] == STG_TOP) begin
        d.ring = RING_MIN;
        d.div2 = 1'b1;
      end else begin
        d.ring = base + RING_STEP;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.ring <= RING_MIN;
    end else begin
      q <= d;
    end
  end

  assign ring_stages = q.ring;
  assign ring_div2 = q.div2;
endmodule : hcg_dither
`default_nettype wire

// *** hw/hcg_ctrl.sv ***
// clock monitor, failover, multiplier and oscillator control with register slave
//
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
`default_nettype none
module hcg_ctrl #(
  parameter logic [6:0] MULT_RST = 7'h15
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [hcg_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [hcg_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [hcg_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [hcg_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic internal_stable_flag,
  input wire logic external_stable_flag,
  input wire logic internal_off,
  input wire logic external_off,
  input wire logic slow_external_option,
  input wire logic loop_filter_up,
  input wire logic loop_filter_down,
  input wire logic loop_filter_coarse,
  output logic irq,
  output logic osc_output_sel_ext,
  output logic timebase_sel_ext,
  output logic internal_osc_on,
  output logic external_osc_on,
  output logic monitor_active,
  output logic monitor_slow_ext,
  output logic [6:0] mult_factor,
  output logic [7:0] trim_value,
  output logic [3:0] osc_divider_field,
  output logic [7:0] osc_stage_field,
  output logic [3:0] eff_div_log2,
  output logic [4:0] ring_stages,
  output logic ring_div2,
  output logic settle_req
);
  import hcg_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    hit = (a == off);
  endfunction : hit

  // codes above the top act as the top
  function automatic logic [3:0] div_clamp(input logic [3:0] v);
    div_clamp = (v > DIV_MAX) ? DIV_MAX : v;
  endfunction : div_clamp

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = hit(a, OFF_CTRL) | hit(a, OFF_MULT) | hit(a, OFF_TRIM) |
             hit(a, OFF_DCO) | hit(a, OFF_STAT);
  endfunction : mapped

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] waddr;
    logic [7:0] wdata;
    logic wlane;
    logic bvalid;
    logic [1:0] bresp;
    hcg_rd_e rd;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
    logic irq_en;
    logic loss;
    logic mon_en;
    logic sel_ext;
    logic tb_ext;
    logic int_on;
    logic ext_on;
    logic armed;
    logic [6:0] mult;
    logic [7:0] trim;
    logic [11:0] digital_oscillator;
    logic [8:0] step_cnt;
    logic settling;
    logic saw_low;
    logic settle_pulse;
    logic irq;
  } hcg_ctrl_s;
  hcg_ctrl_s q, d;

  logic [7:0] pins;
  logic int_stable;
  logic ext_stable;
  logic int_dead;
  logic ext_dead;
  logic slow_ext;
  logic lf_up;
  logic lf_down;
  logic lf_coarse;
  logic [4:0] ring_len;
  logic div2;

  // ----------------------------------------------------------------
  // pin synchronisers and dither
  // ----------------------------------------------------------------
  hcg_sync #(.W(8)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .din({internal_stable_flag, external_stable_flag, internal_off, external_off,
          slow_external_option, loop_filter_up, loop_filter_down, loop_filter_coarse}),
    .dout(pins)
  );
  assign {int_stable, ext_stable, int_dead, ext_dead, slow_ext, lf_up, lf_down, lf_coarse} = pins;

  hcg_dither u_dither (
    .aclk(aclk),
    .aresetn(aresetn),
    .osc_stage_field(q.digital_oscillator[7:0]),
    .ring_stages(ring_len),
    .ring_div2(div2)
  );

  // ----------------------------------------------------------------
  // register read views
  // ----------------------------------------------------------------
  logic [7:0] ctrl_rd;
  logic [DATA_W-1:0] stat_rd;
  logic [7:0] wv;
  logic do_wr;
  logic [11:0] step;
  logic [8:0] step_len;

  always_comb begin
    ctrl_rd = '0;
    ctrl_rd[B_INT_STABLE] = int_stable;
    ctrl_rd[B_INT_ON] = q.int_on;
    ctrl_rd[B_EXT_STABLE] = ext_stable;
    ctrl_rd[B_EXT_ON] = q.ext_on;
    ctrl_rd[B_SEL_EXT] = q.sel_ext;
    ctrl_rd[B_MON_EN] = q.mon_en;
    ctrl_rd[B_LOSS] = q.loss;
    ctrl_rd[B_IRQ_EN] = q.irq_en;
    stat_rd = '0;
    stat_rd[S_SETTLING] = q.settling;
    stat_rd[S_DIV_LSB +: 4] = div_clamp(q.digital_oscillator[11:8]);
    stat_rd[S_RING_LSB +: 5] = ring_len;
    stat_rd[S_DIV2] = div2;
    stat_rd[S_SLOW_EXT] = slow_ext;
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.settle_pulse = 1'b0;
    wv = q.wdata;
    // both halves held and no response pending
    do_wr = q.aw_got & q.w_got & ~q.bvalid;
    step = lf_coarse ? STEP_COARSE : STEP_FINE;
    // one correction per four base periods, i.e. 4*N internal cycles
    step_len = 9'(CORR_BASE_PERIODS * q.mult);

    // write channels taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      d.aw_got = 1'b1;
      d.waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      d.w_got = 1'b1;
      d.wdata = s_axi_wdata[7:0];
      d.wlane = s_axi_wstrb[0];
    end
    if (do_wr) begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = mapped(q.waddr) ? RESP_OKAY : RESP_SLVERR;
      if (hit(q.waddr, OFF_CTRL) && q.wlane) begin
        d.int_on = wv[B_INT_ON];
        d.ext_on = wv[B_EXT_ON];
        // switch only to a clock that is on and stable
        if (wv[B_SEL_EXT] && wv[B_EXT_ON] && q.ext_on && ext_stable) begin
          d.sel_ext = 1'b1;
        end else if (!wv[B_SEL_EXT] && q.int_on && int_stable) begin
          d.sel_ext = 1'b0;
        end
        // clear needs a prior read that saw the flag; a one does nothing
        if (q.armed && !wv[B_LOSS]) begin
          d.loss = 1'b0;
        end
        d.armed = 1'b0;
        // only software clears it; later loss of stability does not
        if (!wv[B_MON_EN]) begin
          d.mon_en = 1'b0;
        end else if (int_stable && ext_stable && q.int_on && q.ext_on &&
                     !q.settling) begin
          d.mon_en = 1'b1;
        end
        d.irq_en = wv[B_IRQ_EN] & q.mon_en;
      end
      if (hit(q.waddr, OFF_MULT) && q.wlane && q.wdata[6:0] != q.mult) begin
        d.mult = q.wdata[6:0];
        d.settling = 1'b1;
        d.saw_low = 1'b0;
        d.settle_pulse = 1'b1;
      end
      if (hit(q.waddr, OFF_TRIM) && q.wlane && q.wdata != q.trim) begin
        d.trim = q.wdata;
        d.settling = 1'b1;
        d.saw_low = 1'b0;
        d.settle_pulse = 1'b1;
      end
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end

    // internal generator restart also settles
    if (d.int_on && !q.int_on) begin
      d.settling = 1'b1;
      d.saw_low = 1'b0;
      d.settle_pulse = 1'b1;
    end

    // read channel
    if (q.rd == RD_IDLE && s_axi_arvalid) begin
      d.rd = RD_DATA;
      d.rresp = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      d.rdata = '0;
      if (hit(s_axi_araddr, OFF_CTRL)) begin
        // reading control is the first half of clearing the loss flag
        d.rdata[7:0] = ctrl_rd;
        d.armed = q.loss;
      end
      if (hit(s_axi_araddr, OFF_MULT)) d.rdata[6:0] = q.mult;
      if (hit(s_axi_araddr, OFF_TRIM)) d.rdata[7:0] = q.trim;
      if (hit(s_axi_araddr, OFF_DCO)) d.rdata[11:0] = q.digital_oscillator;
      if (hit(s_axi_araddr, OFF_STAT)) d.rdata = stat_rd;
    end else if (q.rd == RD_DATA && s_axi_rready) begin
      d.rd = RD_IDLE;
    end

    // stable flag must drop and return before settling ends;
    // a request in this very cycle restarts the watch instead
    if (q.settling && !d.settle_pulse) begin
      if (!int_stable) begin
        d.saw_low = 1'b1;
      end
      if (q.saw_low && int_stable) begin
        d.settling = 1'b0;
      end
    end

    // loop filter corrections; the divider moves only by carry or borrow
    if (q.step_cnt == '0) begin
      d.step_cnt = step_len - 9'h001;
      if (lf_up && !lf_down) begin
        d.digital_oscillator = (q.digital_oscillator > DCO_MAX - step) ? DCO_MAX : q.digital_oscillator + step;
      end else if (lf_down && !lf_up) begin
        d.digital_oscillator = (q.digital_oscillator < step) ? '0 : q.digital_oscillator - step;
      end
    end else begin
      d.step_cnt = q.step_cnt - 9'h001;
    end

    // irq enable cannot outlive the monitor
    if (!d.mon_en) begin
      d.irq_en = 1'b0;
    end
    // failover; detection set wins over a same-cycle clear
    if (q.mon_en && (int_dead || ext_dead)) begin
      d.loss = 1'b1;
      if (int_dead && !ext_dead) begin
        d.sel_ext = 1'b1;
      end else if (ext_dead && !int_dead) begin
        d.sel_ext = 1'b0;
      end
    end
    // timebase follows external on, unless failover chose a survivor
    d.tb_ext = d.loss ? d.sel_ext : d.ext_on;
    d.irq = d.loss & d.irq_en;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.mult <= MULT_RST;
      q.trim <= TRIM_RST;
      q.int_on <= 1'b1;
      q.settling <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign s_axi_awready = ~q.aw_got & ~q.bvalid;
  assign s_axi_wready = ~q.w_got & ~q.bvalid;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = (q.rd == RD_IDLE);
  assign s_axi_rvalid = (q.rd == RD_DATA);
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;

  // ----------------------------------------------------------------
  // clock control outputs
  // ----------------------------------------------------------------
  assign irq = q.irq;
  assign osc_output_sel_ext = q.sel_ext;
  assign timebase_sel_ext = q.tb_ext;
  assign internal_osc_on = q.int_on;
  assign external_osc_on = q.ext_on;
  assign monitor_active = q.mon_en;
  // detection thresholds only fit when this matches the real external clock
  assign monitor_slow_ext = slow_ext;
  assign mult_factor = q.mult;
  assign trim_value = q.trim;
  assign osc_divider_field = q.digital_oscillator[11:8];
  assign osc_stage_field = q.digital_oscillator[7:0];
  // error over one cycle shrinks as the divider grows
  assign eff_div_log2 = div_clamp(q.digital_oscillator[11:8]);
  assign ring_stages = ring_len;
  assign ring_div2 = div2;
  assign settle_req = q.settle_pulse;
endmodule : hcg_ctrl
`default_nettype wire

// *** tb/hcg_clk_model.sv ***
// status model of the two oscillators seen by the clock control block
`default_nettype none
module hcg_clk_model #(
  parameter int SETTLE = 40,
  parameter int EXT_DLY = 20
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic internal_osc_on,
  input wire logic external_osc_on,
  input wire logic settle_req,
  input wire logic kill_int,
  input wire logic kill_ext,
  input wire logic shake,
  output logic internal_stable_flag,
  output logic external_stable_flag,
  output logic internal_off,
  output logic external_off
);
  timeunit 1ns;
  timeprecision 1ns;
  int ic = 0;
  int ec = 0;
  // ---------------------------------------------------------------
  // stability counters
  // ---------------------------------------------------------------
  always @(posedge aclk) begin
    // restart drops the stable flag so the block sees low then high
    if (!aresetn || settle_req || !internal_osc_on || kill_int || shake) begin
      ic <= 0;
    end else if (ic < SETTLE) begin
      ic <= ic + 1;
    end
    if (!external_osc_on || kill_ext) begin
      ec <= 0;
    end else if (ec < EXT_DLY) begin
      ec <= ec + 1;
    end
  end
  assign internal_stable_flag = (ic == SETTLE);
  assign external_stable_flag = (ec == EXT_DLY);
  // both keep running unless a scenario kills one
  assign internal_off = kill_int;
  assign external_off = kill_ext;
endmodule : hcg_clk_model
`default_nettype wire

// *** tb/hcg_ctrl_properties.sv ***
// concurrent checks on the clock control block ports
`default_nettype none
module hcg_ctrl_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic internal_stable_flag,
  input wire logic external_stable_flag,
  input wire logic internal_off,
  input wire logic external_off,
  input wire logic irq,
  input wire logic osc_output_sel_ext,
  input wire logic timebase_sel_ext,
  input wire logic monitor_active,
  input wire logic [6:0] mult_factor,
  input wire logic [3:0] osc_divider_field,
  input wire logic [7:0] osc_stage_field,
  input wire logic [3:0] eff_div_log2,
  input wire logic [4:0] ring_stages,
  input wire logic ring_div2,
  input wire logic settle_req
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  chk_mon_stable: assert property (
    $rose(monitor_active) |-> internal_stable_flag && external_stable_flag)
    else $error("monitor enabled without stable clocks");
  chk_mon_holds: assert property (
    monitor_active && $fell(internal_stable_flag) |=> monitor_active)
    else $error("monitor dropped on stability loss");
  chk_fail_ext: assert property (
    monitor_active && internal_off |-> ##[1:8] osc_output_sel_ext)
    else $error("no failover to external clock");
  chk_fail_int: assert property (
    monitor_active && external_off |-> ##[1:8] !osc_output_sel_ext)
    else $error("no failover to internal clock");
  chk_tb_follow: assert property (
    $fell(osc_output_sel_ext) && monitor_active |-> ##[0:2] !timebase_sel_ext)
    else $error("timebase kept the lost clock");
  chk_irq_mon: assert property (
    $fell(monitor_active) |-> ##[0:2] !irq)
    else $error("irq stays after monitor off");
  chk_div_clamp: assert property (
    $stable(osc_divider_field) [*2] |->
      eff_div_log2 == ((osc_divider_field > 4'h9) ? 4'h9 : osc_divider_field))
    else $error("divider clamp wrong");
  chk_ring_len: assert property (
    $stable(osc_stage_field) [*3] ##0 osc_stage_field[4:0] == 5'h00 |->
      ring_stages == 5'h11 + {1'b0, osc_stage_field[7:5], 1'b0} && !ring_div2)
    else $error("ring length wrong");
  chk_top_dither: assert property (
    $stable(osc_stage_field) [*3] ##0 osc_stage_field == 8'hff |->
      (ring_div2 || $past(ring_div2)) && (!ring_div2 || ring_stages == 5'h11))
    else $error("top code dither wrong");
  chk_div_carry: assert property (
    $changed(osc_divider_field) |-> $changed(osc_stage_field))
    else $error("divider moved without stage carry");
  chk_settle_pulse: assert property (
    $changed(mult_factor) |-> ##[0:1] settle_req)
    else $error("no settling after multiplier change");
endmodule : hcg_ctrl_properties
bind hcg_ctrl hcg_ctrl_properties chk_u (.*);
`default_nettype wire

// *** tb/tb_hcg_ctrl.sv ***
// self-checking bench for the clock control block
`default_nettype none
module tb_hcg_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  import hcg_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = 5'h00;
  logic [ADDR_W-1:0] s_axi_araddr = 5'h00;
  logic [DATA_W-1:0] s_axi_wdata = '0;
  logic [DATA_W-1:0] s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic internal_stable_flag, external_stable_flag, internal_off, external_off;
  logic slow_external_option = 0, loop_filter_up = 0, loop_filter_down = 0;
  logic loop_filter_coarse = 0, kill_int = 0, kill_ext = 0, shake = 0;
  logic irq, osc_output_sel_ext, timebase_sel_ext, internal_osc_on, external_osc_on;
  logic monitor_active, monitor_slow_ext, ring_div2, settle_req;
  logic [6:0] mult_factor;
  logic [7:0] trim_value, osc_stage_field;
  logic [3:0] osc_divider_field, eff_div_log2;
  logic [4:0] ring_stages;
  int n_mismatch = 0;
  int cmp_count = 0;
  hcg_ctrl dut_u (.*);
  hcg_clk_model src_u (.*);
  initial begin
    forever #25 aclk = ~aclk;
  end
  // ---------------------------------------------------------------
  // compare and bus tasks
  // ---------------------------------------------------------------
  task automatic ck_dat(input logic [31:0] g, input logic [11:0] e, m);
    cmp_count++;
    if ((g & {20'h0_0000, m}) !== {20'h0_0000, e & m}) begin
      n_mismatch++;
      $display("BAD %0t data %h exp %h", $time, g, e);
    end
  endtask : ck_dat
  task automatic ck_rsp(input logic [1:0] g, e);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %0t resp %h exp %h", $time, g, e);
    end
  endtask : ck_rsp
  task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    ck_rsp(s_axi_bresp, er);
    @(posedge aclk);
  endtask : wr
  task automatic rc(input logic [4:0] a, input logic [11:0] e, m, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    ck_rsp(s_axi_rresp, er);
    ck_dat(s_axi_rdata, e, m);
    @(posedge aclk);
  endtask : rc
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim
  initial begin
    repeat (30000) @(posedge aclk);
    n_mismatch++;
    end_sim();
  end
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    int k;
    logic s;
    logic [7:0] w;
    void'($urandom(32'h0642_4dc4));
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rc(OFF_STAT, 12'h221, 12'hfff, RESP_OKAY);
    rc(5'h14, 12'h000, 12'hfff, RESP_SLVERR);
    wr(5'h14, 8'hff, RESP_SLVERR);
    rc(OFF_MULT, 12'h015, 12'h07f, RESP_OKAY);
    wr(OFF_CTRL, 8'h22, RESP_OKAY);
    rc(OFF_CTRL, 12'h002, 12'h0fa, RESP_OKAY);
    wr(OFF_CTRL, 8'h0a, RESP_OKAY);
    repeat (60) @(posedge aclk);
    wr(OFF_MULT, 8'h01, RESP_OKAY);
    wr(OFF_CTRL, 8'h2a, RESP_OKAY);
    rc(OFF_CTRL, 12'h00a, 12'h0fa, RESP_OKAY);
    wr(OFF_TRIM, 8'h7f, RESP_OKAY);
    rc(OFF_TRIM, 12'h07f, 12'h0ff, RESP_OKAY);
    ck_dat({24'h00_0000, trim_value}, 12'h07f, 12'h0ff);
    repeat (60) @(posedge aclk);
    rc(OFF_CTRL, 12'h00f, 12'hfff, RESP_OKAY);
    rc(OFF_STAT, 12'h000, 12'h001, RESP_OKAY);
    ck_dat({30'h0, internal_osc_on, external_osc_on}, 12'h003, 12'h003);
    for (k = 0; k < 2; k++) begin
      s = k[0];
      w = {3'b000, s, 4'ha};
      wr(OFF_CTRL, w | 8'h20, RESP_OKAY);
      wr(OFF_CTRL, w | 8'ha0, RESP_OKAY);
      rc(OFF_CTRL, {4'h0, w | 8'ha5}, 12'hfff, RESP_OKAY);
      shake <= 1'b1;
      repeat (10) @(posedge aclk);
      shake <= 1'b0;
      rc(OFF_CTRL, {4'h0, w | 8'ha4}, 12'hfff, RESP_OKAY);
      repeat (60) @(posedge aclk);
      if (k == 0) kill_int <= 1'b1;
      else kill_ext <= 1'b1;
      repeat (20) @(posedge aclk);
      ck_dat({31'h0, irq}, 12'h001, 12'h001);
      ck_dat({31'h0, timebase_sel_ext}, {11'h0, ~s}, 12'h001);
      ck_dat({31'h0, osc_output_sel_ext}, {11'h0, ~s}, 12'h001);
      rc(OFF_CTRL, {4'h0, 8'hea | {3'b000, ~s, 1'b0, ~s, 1'b0, s}}, 12'hfff, RESP_OKAY);
      kill_int <= 1'b0;
      kill_ext <= 1'b0;
      repeat (60) @(posedge aclk);
      w = {3'b000, ~s, 4'ha};
      wr(OFF_CTRL, w | 8'he0, RESP_OKAY);
      wr(OFF_CTRL, w | 8'ha0, RESP_OKAY);
      rc(OFF_CTRL, {4'h0, w | 8'he5}, 12'hfff, RESP_OKAY);
      wr(OFF_CTRL, w | 8'ha0, RESP_OKAY);
      rc(OFF_CTRL, {4'h0, w | 8'ha5}, 12'hfff, RESP_OKAY);
      ck_dat({31'h0, irq}, 12'h000, 12'h001);
      wr(OFF_CTRL, w, RESP_OKAY);
      rc(OFF_CTRL, {4'h0, w | 8'h05}, 12'hfff, RESP_OKAY);
    end
    // multiplier of one keeps each correction step four cycles long
    slow_external_option <= 1'b1;
    loop_filter_coarse <= 1'b1;
    loop_filter_up <= 1'b1;
    repeat (600) @(posedge aclk);
    ck_dat({31'h0, monitor_slow_ext}, 12'h001, 12'h001);
    loop_filter_coarse <= 1'b0;
    repeat (200) @(posedge aclk);
    rc(OFF_DCO, 12'h9ff, 12'hfff, RESP_OKAY);
    rc(OFF_STAT, 12'h812, 12'h81f, RESP_OKAY);
    repeat (300) begin
      @(posedge aclk);
      {loop_filter_up, loop_filter_down, loop_filter_coarse} <= 3'($urandom);
    end
    @(posedge aclk);
    {loop_filter_up, loop_filter_down, loop_filter_coarse} <= 3'b011;
    repeat (600) @(posedge aclk);
    loop_filter_coarse <= 1'b0;
    repeat (200) @(posedge aclk);
    rc(OFF_DCO, 12'h000, 12'hfff, RESP_OKAY);
    rc(OFF_STAT, 12'ha20, 12'hfff, RESP_OKAY);
    end_sim();
  end
endmodule : tb_hcg_ctrl
`default_nettype wire
